// ---- dpf_host_flags.sv ----
// host command decoder: flag clearing, skip requests, interrupt and read-back words
module dpf_host_flags
  import dpf_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire dpf_word_t   iot_word_i,
  input  wire logic [2:0]  io_timing_pulse_i,
  input  wire dpf_word_t   accumulator_i,
  input  wire logic [5:0]  button_i,
  input  wire dpf_params_t params_i,
  input  wire dpf_engine_t engine_i,
  output logic             skip_request_o,
  output dpf_word_t        read_data_o,
  output logic             read_drive_o,
  output logic             program_interrupt_o,
  output logic [1:0]       area_size_o,
  output logic             halt_request_o,
  output logic             resume_display_o
);

  typedef struct packed {
    dpf_word_t  iot_meta;
    dpf_word_t  iot_sync;
    dpf_word_t  ac_meta;
    dpf_word_t  ac_sync;
    logic [2:0] iop_meta;
    logic [2:0] iop_sync;
    logic [2:0] iop_prev;
    logic [5:0] button_meta;
    logic [5:0] button_sync;
    logic [4:0] flags;
    logic [4:0] enables;
    logic [1:0] area;
    logic       halt_pending;
    logic       resume;
    logic       skip;
    logic       read_active;
    dpf_word_t  read_data;
    logic       interrupt;
  } dpf_state_t;

  dpf_state_t state;
  dpf_state_t next_state;

  logic       cmd_ok;
  logic [2:0] cmd;
  logic       op_fire;
  logic       skip_hit;
  logic       read_hit;
  dpf_word_t  read_word;
  logic [4:0] armed;

  // command decode from the synchronised instruction word
  always_comb begin
    cmd_ok = (state.iot_sync[IOT_OP_MSB:IOT_OP_LSB] == IOT_OPCODE)
             && ((state.iot_sync[IOT_DEV_MSB:IOT_DEV_LSB] == IOT_DEV_A)
             || (state.iot_sync[IOT_DEV_MSB:IOT_DEV_LSB] == IOT_DEV_B));
    cmd = {state.iot_sync[IOT_DEV_MSB:IOT_DEV_LSB] == IOT_DEV_B,
           state.iot_sync[IOT_SUB_MSB:IOT_SUB_LSB]};
    op_fire = cmd_ok && state.iop_sync[IOP4] && !state.iop_prev[IOP4];
    armed = state.flags & state.enables;
  end

  // skip condition for the current command
  always_comb begin
    skip_hit = 1'h0;
    if (cmd_ok) begin
      unique case (cmd)
        SK_HALT:      skip_hit = state.flags[FL_HALT];
        SK_PEN:       skip_hit = state.flags[FL_PEN];
        SK_BUTTON:    skip_hit = state.flags[FL_BUTTON] | (|state.button_sync);
        SK_BOUNDARY:  skip_hit = state.flags[FL_BOUNDARY];
        SK_ANY:       skip_hit = |state.flags;
        SK_ENABLED:   skip_hit = |armed;
        SK_HOST_HALT: skip_hit = state.flags[FL_HOST_HALT];
        default:      skip_hit = 1'h0;
      endcase
    end
  end

  // read-back word for the current command
  always_comb begin
    read_word = '0;
    read_hit  = 1'h0;
    if (cmd_ok) begin
      unique case (cmd)
        RD_STATUS_A: begin
          read_hit                                = 1'h1;
          read_word[SA_OFFSET]                    = params_i.offset;
          read_word[SA_ROTATE]                    = params_i.rotate;
          read_word[SA_BLINK]                     = params_i.blink;
          read_word[SA_AREA_HIGH]                 = state.area[1];
          read_word[SA_AREA_LOW]                  = state.area[0];
          read_word[SA_INC:SA_INC+3]              = params_i.increment;
          read_word[SA_ENABLE]                    = state.enables[FL_HALT];
          read_word[SA_ENABLE+1]                  = state.enables[FL_PEN];
          read_word[SA_ENABLE+2]                  = state.enables[FL_BOUNDARY];
          read_word[SA_ENABLE+3]                  = state.enables[FL_BUTTON];
          read_word[SA_PEN_FLAG_EN]               = params_i.pen_flag_enable;
          read_word[SA_LINE:SA_LINE+1]            = params_i.line;
        end
        RD_STATUS_B: begin
          read_hit                                = 1'h1;
          read_word[SB_BUTTON:SB_BUTTON+5]        = state.button_sync;
          read_word[SB_MOVE]                      = params_i.move;
          read_word[SB_BOUND_EN]                  = params_i.boundary_flag_enable;
          read_word[SB_INTENSITY:SB_INTENSITY+2]  = params_i.intensity;
          read_word[SB_NAME:SB_NAME+5]            = params_i.name;
        end
        RD_FLAGS: begin
          read_hit                                = 1'h1;
          read_word[SF_HALT]                      = state.flags[FL_HALT];
          read_word[SF_BUTTON]                    = state.flags[FL_BUTTON];
          read_word[SF_PEN]                       = state.flags[FL_PEN];
          read_word[SF_BOUNDARY]                  = state.flags[FL_BOUNDARY];
          read_word[SF_HOST_HALT]                 = state.flags[FL_HOST_HALT];
        end
        RD_PC: begin
          read_hit                                = 1'h1;
          read_word[1:17]                         = engine_i.program_counter;
        end
        RD_XPOS: begin
          read_hit                                = 1'h1;
          read_word[SP_OVERFLOW]                  = engine_i.x_overflow;
          read_word[SP_VALUE:17]                  = engine_i.x_position;
        end
        RD_YPOS: begin
          read_hit                                = 1'h1;
          read_word[SP_OVERFLOW]                  = engine_i.y_overflow;
          read_word[SP_VALUE:17]                  = engine_i.y_position;
        end
        default: begin
          read_hit                                = 1'h0;
        end
      endcase
    end
  end

  // next state: synchronisers, operate commands, flag setting
  always_comb begin
    next_state             = state;
    next_state.iot_meta    = iot_word_i;
    next_state.iot_sync    = state.iot_meta;
    next_state.ac_meta     = accumulator_i;
    next_state.ac_sync     = state.ac_meta;
    next_state.iop_meta    = io_timing_pulse_i;
    next_state.iop_sync    = state.iop_meta;
    next_state.iop_prev    = state.iop_sync;
    next_state.button_meta = button_i;
    next_state.button_sync = state.button_meta;
    next_state.resume      = 1'h0;

    // operate commands act once, on the rising edge of pulse 4
    if (op_fire) begin
      unique case (cmd)
        OP_INITIALIZE: begin
          for (int i = 0; i < NUM_FLAGS; i++) begin
            next_state.enables[i] = state.ac_sync[ACB_ENABLE+i];
            if (state.ac_sync[ACB_CLEAR+i]) begin
              next_state.flags[i] = 1'h0;
            end
          end
          if (state.ac_sync[ACB_AREA_LOAD]) begin
            next_state.area = {state.ac_sync[ACB_AREA_HIGH],
                               state.ac_sync[ACB_AREA_LOW]};
          end
        end
        OP_HOST_HALT: begin
          next_state.halt_pending = 1'h1;
        end
        OP_RESUME: begin
          next_state.flags        = '0;
          next_state.halt_pending = 1'h0;
          next_state.resume       = 1'h1;
        end
        OP_CLEAR_ALL: begin
          next_state.flags = '0;
        end
        default: begin
          next_state.flags = state.flags;
        end
      endcase
    end

    // hardware sets win over a clear in the same cycle
    if (engine_i.halt_flag_set) begin
      next_state.flags[FL_HALT] = 1'h1;
    end
    if (engine_i.pen_flag_set) begin
      next_state.flags[FL_PEN] = 1'h1;
    end
    if (params_i.boundary_flag_enable && engine_i.beam_beyond_area) begin
      next_state.flags[FL_BOUNDARY] = 1'h1;
    end
    if (|state.button_sync) begin
      next_state.flags[FL_BUTTON] = 1'h1;
    end
    if (state.halt_pending && engine_i.halted) begin
      next_state.flags[FL_HOST_HALT] = 1'h1;
      next_state.halt_pending        = 1'h0;
    end

    // skip and read answers exist only while their pulse stands
    next_state.skip        = state.iop_sync[IOP1] && skip_hit;
    next_state.read_active = state.iop_sync[IOP2] && read_hit;
    next_state.read_data   = (state.iop_sync[IOP2] && read_hit) ? read_word : '0;
    next_state.interrupt   = |armed;
  end

  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      state         <= '0;
      state.flags   <= FLAGS_RESET;
      state.enables <= ENABLES_RESET;
      state.area    <= AREA_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign skip_request_o      = state.skip;
  assign read_data_o         = state.read_data;
  assign read_drive_o        = state.read_active;
  assign program_interrupt_o = state.interrupt;
  assign area_size_o         = state.area;
  assign halt_request_o      = state.halt_pending;
  assign resume_display_o    = state.resume;

endmodule : dpf_host_flags

// ---- dpf_pkg.sv ----
// package: command codes, word layouts and carrier types of the host flag/skip/read block
package dpf_pkg;

  // host word, bit 0 is the most significant bit as the host numbers it
  typedef logic [0:17] dpf_word_t;

  // programmed_io_command fields
  localparam int        IOT_OP_MSB     = 0;
  localparam int        IOT_OP_LSB     = 5;
  localparam int        IOT_DEV_MSB    = 6;
  localparam int        IOT_DEV_LSB    = 11;
  localparam int        IOT_SUB_MSB    = 12;
  localparam int        IOT_SUB_LSB    = 13;
  localparam logic [5:0] IOT_OPCODE    = 6'h38;
  localparam logic [5:0] IOT_DEV_A     = 6'h18;
  localparam logic [5:0] IOT_DEV_B     = 6'h19;

  // command index: {device B selected, subdevice}
  localparam logic [2:0] OP_INITIALIZE = 3'h0;
  localparam logic [2:0] OP_HOST_HALT  = 3'h1;
  localparam logic [2:0] OP_RESUME     = 3'h2;
  localparam logic [2:0] OP_CLEAR_ALL  = 3'h3;
  localparam logic [2:0] SK_HALT       = 3'h0;
  localparam logic [2:0] SK_PEN        = 3'h1;
  localparam logic [2:0] SK_BUTTON     = 3'h2;
  localparam logic [2:0] SK_BOUNDARY   = 3'h3;
  localparam logic [2:0] SK_ANY        = 3'h4;
  localparam logic [2:0] SK_ENABLED    = 3'h5;
  localparam logic [2:0] SK_HOST_HALT  = 3'h6;
  localparam logic [2:0] RD_STATUS_A   = 3'h0;
  localparam logic [2:0] RD_STATUS_B   = 3'h1;
  localparam logic [2:0] RD_FLAGS      = 3'h2;
  localparam logic [2:0] RD_PC         = 3'h4;
  localparam logic [2:0] RD_XPOS       = 3'h5;
  localparam logic [2:0] RD_YPOS       = 3'h6;

  // io_timing_pulse indices
  localparam int        IOP1           = 0;
  localparam int        IOP2           = 1;
  localparam int        IOP4           = 2;

  // flag / enable indices (same order for both)
  localparam int        FL_HALT        = 0;
  localparam int        FL_PEN         = 1;
  localparam int        FL_BOUNDARY    = 2;
  localparam int        FL_BUTTON      = 3;
  localparam int        FL_HOST_HALT   = 4;
  localparam int        NUM_FLAGS      = 5;

  // initialize_conditions_cmd accumulator bits
  localparam int        ACB_ENABLE     = 0;
  localparam int        ACB_CLEAR      = 5;
  localparam int        ACB_AREA_LOAD  = 10;
  localparam int        ACB_AREA_HIGH  = 11;
  localparam int        ACB_AREA_LOW   = 12;

  // parameter_status_word_a positions
  localparam int        SA_OFFSET      = 2;
  localparam int        SA_ROTATE      = 3;
  localparam int        SA_BLINK       = 4;
  localparam int        SA_AREA_HIGH   = 5;
  localparam int        SA_AREA_LOW    = 6;
  localparam int        SA_INC         = 7;
  localparam int        SA_ENABLE      = 11;
  localparam int        SA_PEN_FLAG_EN = 15;
  localparam int        SA_LINE        = 16;
  // parameter_status_word_b positions
  localparam int        SB_BUTTON      = 0;
  localparam int        SB_MOVE        = 6;
  localparam int        SB_BOUND_EN    = 7;
  localparam int        SB_INTENSITY   = 9;
  localparam int        SB_NAME        = 12;
  // flag status word, positions of halt, button, pen, boundary, host halt
  localparam int        SF_HALT        = 0;
  localparam int        SF_BUTTON      = 1;
  localparam int        SF_PEN         = 2;
  localparam int        SF_BOUNDARY    = 3;
  localparam int        SF_HOST_HALT   = 4;
  // position words
  localparam int        SP_OVERFLOW    = 5;
  localparam int        SP_VALUE       = 6;

  localparam logic [1:0] AREA_RESET    = 2'h0;
  localparam logic [4:0] FLAGS_RESET   = 5'h00;
  localparam logic [4:0] ENABLES_RESET = 5'h00;

  // parameter registers held by the display engine
  typedef struct packed {
    logic       offset;
    logic       rotate;
    logic       blink;
    logic [3:0] increment;
    logic [1:0] line;
    logic       pen_flag_enable;
    logic       boundary_flag_enable;
    logic       move;
    logic [2:0] intensity;
    logic [5:0] name;
  } dpf_params_t;

  // live status from the display engine, same clock
  typedef struct packed {
    logic        halt_flag_set;
    logic        pen_flag_set;
    logic        beam_beyond_area;
    logic        halted;
    logic [16:0] program_counter;
    logic        x_overflow;
    logic [11:0] x_position;
    logic        y_overflow;
    logic [11:0] y_position;
  } dpf_engine_t;

endpackage : dpf_pkg

// ---- dpf_host_flags_checker.sv ----
// checker: port-level timing and decode properties of the host flag block
module dpf_host_flags_checker
  import dpf_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        resetn_i,
  input  wire dpf_word_t   iot_word_i,
  input  wire logic [2:0]  io_timing_pulse_i,
  input  wire dpf_word_t   accumulator_i,
  input  wire logic [5:0]  button_i,
  input  wire dpf_params_t params_i,
  input  wire dpf_engine_t engine_i,
  input  wire logic        skip_request_o,
  input  wire dpf_word_t   read_data_o,
  input  wire logic        read_drive_o,
  input  wire logic        program_interrupt_o,
  input  wire logic [1:0]  area_size_o,
  input  wire logic        halt_request_o,
  input  wire logic        resume_display_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!resetn_i);

  a_skip_from_pulse: assert property (
    skip_request_o |-> $past(io_timing_pulse_i[IOP1], 3))
    else $error("skip request without pulse one");
  a_read_from_pulse: assert property (
    read_drive_o |-> $past(io_timing_pulse_i[IOP2], 3))
    else $error("read drive without pulse two");
  a_read_idle_zero: assert property (!read_drive_o |-> read_data_o == '0)
    else $error("read data nonzero while idle");
  a_read_opcode_match: assert property (
    read_drive_o |-> $past(iot_word_i[0:5], 3) == IOT_OPCODE)
    else $error("read answered a foreign opcode");
  a_pc_bit_zero: assert property (
    read_drive_o && $past(iot_word_i[6:13], 3) == {IOT_DEV_B, 2'h0}
    |-> !read_data_o[0]) else $error("pc read drives bit 0");
  a_xpos_low_zero: assert property (
    read_drive_o && $past(iot_word_i[6:13], 3) == {IOT_DEV_B, 2'h1}
    |-> read_data_o[0:4] == 5'h00) else $error("position read drives bits 0-4");
  a_status_low_zero: assert property (
    read_drive_o && $past(iot_word_i[6:13], 3) == {IOT_DEV_A, 2'h0}
    |-> read_data_o[0:1] == 2'h0) else $error("status a drives bits 0-1");
  a_area_on_operate: assert property ($changed(area_size_o)
    |-> $past(io_timing_pulse_i[IOP4], 3) || $past(io_timing_pulse_i[IOP4], 4))
    else $error("area size changed without operate pulse");
  a_resume_one_cycle: assert property (resume_display_o |=> !resume_display_o)
    else $error("resume pulse longer than one cycle");
  a_skip_keeps_area: assert property (
    (skip_request_o || read_drive_o) |=> $stable(area_size_o))
    else $error("skip or read changed area size");
  a_halt_req_drop: assert property (
    halt_request_o && engine_i.halted |-> ##[1:4] !halt_request_o)
    else $error("halt request kept after engine halted");
endmodule : dpf_host_flags_checker

bind dpf_host_flags dpf_host_flags_checker chk_u (.clk_i, .resetn_i, .iot_word_i,
  .io_timing_pulse_i, .accumulator_i, .button_i, .params_i, .engine_i, .skip_request_o,
  .read_data_o, .read_drive_o,
  .program_interrupt_o, .area_size_o, .halt_request_o, .resume_display_o);

// ---- dpf_host_model.sv ----
// host processor model: issues programmed io commands, merges read data into its accumulator
module dpf_host_model
  import dpf_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       skip_request_i,
  input  wire dpf_word_t  read_data_i,
  output dpf_word_t       iot_word_o,
  output logic [2:0]      io_timing_pulse_o,
  output dpf_word_t       accumulator_o
);
  timeunit 1ns;
  timeprecision 1ns;
  dpf_word_t acc_reg;

  initial begin
    iot_word_o = '0;
    io_timing_pulse_o = 3'h0;
    accumulator_o = '0;
    acc_reg = '0;
  end

  // word settles two edges ahead, pulse stands five edges, then four low edges
  task automatic xfer(input logic [5:0] dev, input logic [1:0] sub, input int kind,
                      input dpf_word_t acc, output logic skip, output dpf_word_t ac);
    dpf_word_t w;
    w = '0;
    w[0:5] = IOT_OPCODE;
    w[6:11] = dev;
    w[12:13] = sub;
    w[14] = (kind == IOP2);
    w[17 - kind] = 1'b1;
    @(posedge clk_i);
    #1 iot_word_o = w;
    accumulator_o = acc;
    repeat (2) @(posedge clk_i);
    #1 io_timing_pulse_o[kind] = 1'b1;
    repeat (4) @(posedge clk_i);
    #1 skip = skip_request_i;
    if (w[14]) begin
      acc_reg = '0;
    end
    acc_reg = acc_reg | read_data_i;
    ac = acc_reg;
    @(posedge clk_i);
    #1 io_timing_pulse_o[kind] = 1'b0;
    repeat (4) @(posedge clk_i);
    // lines between instructions carry no stale value
    #1 iot_word_o = ~w;
    accumulator_o = ~acc;
  endtask : xfer
endmodule : dpf_host_model

// ---- test_display_host_flag_skip_read.sv ----
// testbench: command sequences against the host flag, skip and read block
module test_display_host_flag_skip_read import dpf_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_i, resetn_i, skip, rdrv, irq, halt_req, resume, resume_seen;
  logic [2:0]  pulses;
  logic [1:0]  area;
  logic [5:0]  buttons;
  dpf_word_t   iot_word, acc_pins, rdata;
  dpf_params_t params;
  dpf_engine_t engine;
  int          err_count, n_tests;

  dpf_host_flags dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .iot_word_i(iot_word),
    .io_timing_pulse_i(pulses), .accumulator_i(acc_pins), .button_i(buttons), .params_i(params),
    .engine_i(engine), .skip_request_o(skip), .read_data_o(rdata), .read_drive_o(rdrv),
    .program_interrupt_o(irq), .area_size_o(area), .halt_request_o(halt_req),
    .resume_display_o(resume));
  dpf_host_model host_u (.clk_i(clk_i), .skip_request_i(skip), .read_data_i(rdata),
    .iot_word_o(iot_word), .io_timing_pulse_o(pulses), .accumulator_o(acc_pins));

  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) if (resume === 1'b1) resume_seen <= 1'b1;

  task automatic final_report();
    if (err_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : final_report
  task automatic check(input dpf_word_t got, input dpf_word_t exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic chk1(input logic got, input logic exp);
    check({17'h0, got}, {17'h0, exp});
  endtask : chk1
  task automatic skp(input logic [2:0] c, input logic e);
    logic      s;
    dpf_word_t a;
    host_u.xfer(c[2] ? IOT_DEV_B : IOT_DEV_A, c[1:0], IOP1, '0, s, a);
    chk1(s, e);
  endtask : skp
  task automatic rd(input logic [2:0] c, input dpf_word_t e);
    logic      s;
    dpf_word_t a;
    host_u.xfer(c[2] ? IOT_DEV_B : IOT_DEV_A, c[1:0], IOP2, '0, s, a);
    check(a, e);
  endtask : rd
  task automatic op(input logic [2:0] c, input dpf_word_t v);
    logic      s;
    dpf_word_t a;
    host_u.xfer(c[2] ? IOT_DEV_B : IOT_DEV_A, c[1:0], IOP4, v, s, a);
  endtask : op
  // mask is {halt flag, pen flag, beam beyond area}
  task automatic fire(input logic [2:0] m);
    @(posedge clk_i);
    #1 {engine.halt_flag_set, engine.pen_flag_set, engine.beam_beyond_area} = m;
    repeat (2) @(posedge clk_i);
    #1 {engine.halt_flag_set, engine.pen_flag_set, engine.beam_beyond_area} = 3'h0;
  endtask : fire

  initial begin
    repeat (5000) @(posedge clk_i);
    err_count++;
    final_report();
  end

  initial begin
    logic      s;
    dpf_word_t a;
    err_count = 0;
    n_tests = 0;
    resetn_i = 1'b0;
    buttons = 6'h00;
    params = '0;
    engine = '0;
    resume_seen = 1'b0;
    repeat (2) @(posedge clk_i);
    #1 resetn_i = 1'b1;
    rd(RD_FLAGS, '0);
    fire(3'h4);
    skp(SK_HALT, 1'b1);
    skp(SK_PEN, 1'b0);
    skp(SK_ANY, 1'b1);
    skp(SK_ENABLED, 1'b0);
    rd(RD_FLAGS, {5'h10, 13'h0});
    op(OP_INITIALIZE, {5'h10, 5'h00, 3'h6, 5'h00});
    chk1(irq, 1'b1);
    check({16'h0, area}, {16'h0, 2'h2});
    skp(SK_ENABLED, 1'b1);
    params = '{offset:1'b1, blink:1'b1, increment:4'h9, line:2'h1,
               pen_flag_enable:1'b1, default:'0};
    rd(RD_STATUS_A, {2'h0, 3'h5, 2'h2, 4'h9, 4'h8, 1'b1, 2'h1});
    op(OP_RESUME, '0);
    chk1(resume_seen, 1'b1);
    chk1(irq, 1'b0);
    rd(RD_FLAGS, '0);
    fire(3'h1);
    skp(SK_BOUNDARY, 1'b0);
    params = '{boundary_flag_enable:1'b1, move:1'b1, intensity:3'h5, name:6'h2A, default:'0};
    fire(3'h1);
    skp(SK_BOUNDARY, 1'b1);
    fire(3'h2);
    skp(SK_PEN, 1'b1);
    buttons = 6'h01;
    skp(SK_BUTTON, 1'b1);
    rd(RD_STATUS_B, {6'h01, 1'b1, 1'b1, 1'b0, 3'h5, 6'h2A});
    buttons = 6'h00;
    rd(RD_FLAGS, {5'h0E, 13'h0});
    op(OP_CLEAR_ALL, '0);
    rd(RD_FLAGS, '0);
    skp(SK_ANY, 1'b0);
    op(OP_INITIALIZE, {5'h01, 13'h0});
    check({16'h0, area}, {16'h0, 2'h2});
    op(OP_HOST_HALT, '0);
    chk1(halt_req, 1'b1);
    skp(SK_HOST_HALT, 1'b0);
    engine.halted = 1'b1;
    skp(SK_HOST_HALT, 1'b1);
    chk1(irq, 1'b1);
    chk1(halt_req, 1'b0);
    engine.halted = 1'b0;
    op(OP_INITIALIZE, {5'h00, 5'h01, 8'h00});
    rd(RD_FLAGS, '0);
    chk1(irq, 1'b0);
    engine.program_counter = 17'h1ABCD;
    engine.x_overflow = 1'b1;
    engine.x_position = 12'hA5C;
    engine.y_position = 12'h3C1;
    rd(RD_PC, {1'b0, 17'h1ABCD});
    rd(RD_XPOS, {5'h00, 1'b1, 12'hA5C});
    rd(RD_YPOS, {6'h00, 12'h3C1});
    rd(3'h3, '0);
    host_u.xfer(6'h1A, 2'h0, IOP2, '0, s, a);
    check(a, '0);
    final_report();
  end
endmodule : test_display_host_flag_skip_read
